// *** rtl/wsfc_pkg.sv ***
/*
  Package for the wave sequencer and fault control core: register map,
  field positions, reset images, timing counts and the checksum function.
  Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM register bus.
*/
package wsfc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CODE_W = 10;
  localparam int NVM_WORDS = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 6;
  typedef logic [NVM_WORDS-1:0][15:0] wsfc_img_t;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CMP_CFG0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CMP_CFG1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DEV_MODE = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_FUNC_CFG = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_FUNC_MIN = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_FUNC_MAX = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_FREQ_ERR = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_COMMON_CFG = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_TRIGGER = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;

  // Word indices of the configuration image
  localparam logic [IDX_W-1:0] W_CMP0 = 3'h0;
  localparam logic [IDX_W-1:0] W_CMP1 = 3'h1;
  localparam logic [IDX_W-1:0] W_MODE = 3'h2;
  localparam logic [IDX_W-1:0] W_FUNC = 3'h3;
  localparam logic [IDX_W-1:0] W_MIN = 3'h4;
  localparam logic [IDX_W-1:0] W_MAX = 3'h5;
  localparam logic [IDX_W-1:0] W_FERR = 3'h6;
  localparam logic [IDX_W-1:0] W_COMMON = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_GAIN_LSB = 0;
  localparam int F_CMP_EN = 3;
  localparam int F_CMP_OUT_EN = 4;
  localparam int F_CMP_OD = 5;
  localparam int F_CMP_INV = 6;
  localparam int F_FB_HIZ = 7;
  localparam int F_MODE_IN_DIS = 0;
  localparam int F_SHAPE_LSB = 0;
  localparam int F_CSTEP_LSB = 3;
  localparam int F_TSTEP_LSB = 7;
  localparam int F_SEQ_RUN = 11;
  localparam int F_LOCK = 0;
  localparam int F_RST_LSB = 0;
  localparam int F_BYP_LSB = 4;
  localparam int F_PROG = 8;
  localparam int S_FAIL_USER = 0;
  localparam int S_FAIL_FACT = 1;
  localparam int S_BUSY = 2;
  localparam int S_CODE_LSB = 16;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] GAIN_EXT_REF = 3'h0;
  localparam logic [2:0] SHAPE_TRI = 3'h0;
  localparam logic [2:0] SHAPE_SAW = 3'h1;
  localparam logic [2:0] SHAPE_ISAW = 3'h2;
  localparam logic [3:0] RESET_CODE = 4'hA;
  localparam logic [3:0] BYPASS_CODE = 4'h5;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  // ----------------------------------------------------------------
  // Reset images and writable bits
  // ----------------------------------------------------------------
  localparam wsfc_img_t FACT_IMG = {16'h0000, 16'h0000, 16'h03FF, 16'h0000,
                                    16'h0800, 16'h0000, 16'h0001, 16'h0001};
  localparam wsfc_img_t WR_MASK = {16'h0001, 16'h00FF, 16'h03FF, 16'h03FF,
                                   16'h0FFF, 16'h0001, 16'h00FF, 16'h00FF};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_TICK_NS = 1000;
  localparam int BOOT_DELAY_NS = 5000;
  localparam logic [15:0] OSC_TICK_CYC = 16'(OSC_TICK_NS / CLK_PERIOD_NS);
  localparam logic [15:0] BOOT_DELAY_CYC = 16'(BOOT_DELAY_NS / CLK_PERIOD_NS);

  // CRC-16-CCITT over one 16-bit word, msb first
  function automatic logic [15:0] wsfc_crc_word(input logic [15:0] crc, input logic [15:0] w);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ w[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // CRC over a whole image
  function automatic logic [15:0] wsfc_crc_img(input wsfc_img_t img);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < NVM_WORDS; i++) begin
      c = wsfc_crc_word(c, img[i]);
    end
    return c;
  endfunction

  localparam logic [15:0] FACT_CRC = wsfc_crc_img(FACT_IMG);

endpackage

// *** rtl/wsfc_core.sv ***
/*
  Wave sequencer and fault control core: Avalon-MM register slave, boot
  sequence with stored-image checksum, write lock, ramp generator and the
  comparator output stage control.
  Assumes cmp_raw comes from an analog comparator (asynchronous) and all
  other inputs are synchronous to clock.
*/
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns

// Function
// - External reference used when gain selects it
// - Mode pin input disable bit gates stage
// - Comparator mode needs enable and output enable
// - Open-drain bit picks output stage type
// - Invert bit inverts comparator output
// - Feedback high impedance bit selects Hi-Z input
// - Shape zero selects triangle between levels
// - Triangle steps code once per interval
// - Shapes one and two select sawtooth variants
// - Sawtooth period is ceiling plus one steps
// - Codes are ten bits wide
// - Oscillator error presented as signed value
// - Boot loads defaults, bus waits for delay
// - Reset code starts full power-on sequence
// - Write lock blocks register writes
// - Software reset accepted while locked
// - Bypass code overrides active write lock
// - CRC computed at program and start-up
// - Check image, report user and factory fails
// - Fail bits change only during boot and on software reset
// - Fail loads factory values, stays writable
// - Software reset clears fails, reloads store
module wsfc_core
  import wsfc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Analog comparator results, asynchronous
  input wire logic [1:0] cmp_raw,
  // Converter and analog control
  output logic [CODE_W-1:0] dac_code,
  output logic [1:0] ext_ref_sel,
  output logic mode_pin_input_disable,
  output logic [1:0] feedback_high_impedance_select,
  // Comparator output pins, open-drain capable
  output logic [1:0] cmp_o,
  output logic [1:0] cmp_oe,
  output logic boot_done
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_DELAY, ST_CHECK, ST_LOAD, ST_RUN, ST_PROG} wsfc_state_e;

  wsfc_state_e st_q, st_d;
  wsfc_img_t cfg_q, cfg_d, nvm_q, nvm_d;
  logic [15:0] nvm_crc_q, nvm_crc_d, crc_q, crc_d, fcrc_q, fcrc_d;
  logic [15:0] cnt_q, cnt_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic fail_user_q, fail_user_d, fail_fact_q, fail_fact_d;
  logic ack_q, ack_d, wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] raw_m_q, raw_s_q;
  logic [15:0] osc_q, osc_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic dir_down_q, dir_down_d;
  logic [1:0] cmp_o_q, cmp_o_d, cmp_oe_q, cmp_oe_d, ext_q, ext_d, hiz_q, hiz_d;
  logic mode_dis_q, mode_dis_d;
  logic wr_fire, step_tick, run, locked;
  logic [15:0] wmask;
  logic [3:0] tr_rst, tr_byp;
  logic [2:0] shape;
  logic [CODE_W:0] lo, hi, stp, up_v, dn_v;
  logic boot_q, boot_d;

  // Byte enables turned into a 16-bit lane mask
  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Clamp a wide code to the programmed levels; the low level wins if they cross
  function automatic logic [CODE_W-1:0] clamp(input logic [CODE_W:0] v,
                                               input logic [CODE_W:0] l,
                                               input logic [CODE_W:0] h);
    logic [CODE_W:0] r;
    r = (v > h) ? h : v;
    r = (r < l) ? l : r;
    return r[CODE_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Comparator input synchroniser
  // ----------------------------------------------------------------
  // Two plain flops; only the second one is looked at
  always_ff @(posedge clock) begin
    if (!rstn) begin
      raw_m_q <= 2'h0;
      raw_s_q <= 2'h0;
    end else if (ce) begin
      raw_m_q <= cmp_raw;
      raw_s_q <= raw_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus, boot, store and configuration
  // ----------------------------------------------------------------
  assign wr_fire = ack_q & write;
  assign locked = cfg_q[W_COMMON][F_LOCK];
  assign wmask = lane_mask(byteenable);
  assign tr_rst = writedata[F_RST_LSB +: 4];
  assign tr_byp = writedata[F_BYP_LSB +: 4];

  // Next state of the control group
  always_comb begin
    st_d = st_q;
    cfg_d = cfg_q;
    nvm_d = nvm_q;
    nvm_crc_d = nvm_crc_q;
    crc_d = crc_q;
    fcrc_d = fcrc_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    fail_user_d = fail_user_q;
    fail_fact_d = fail_fact_q;
    ack_d = (read | write) & ~ack_q & (st_q == ST_RUN);
    wait_d = ~ack_d;
    rdata_d = rdata_q;
    if (ack_d && read) begin
      unique case (address)
        OFS_CMP_CFG0, OFS_CMP_CFG1, OFS_DEV_MODE, OFS_FUNC_CFG, OFS_FUNC_MIN, OFS_FUNC_MAX,
        OFS_COMMON_CFG: rdata_d = {16'h0000, cfg_q[address[4:2]]};
        OFS_FREQ_ERR: rdata_d = {{24{cfg_q[W_FERR][7]}}, cfg_q[W_FERR][7:0]};
        OFS_STATUS: rdata_d = {6'h00, code_q, 13'h0000, 1'b0,
                               fail_fact_q, fail_user_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    unique case (st_q)
      ST_DELAY: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == BOOT_DELAY_CYC - 16'h0001) begin
          st_d = ST_CHECK;
          idx_d = '0;
          crc_d = CRC_INIT;
          fcrc_d = CRC_INIT;
        end
      end
      ST_CHECK: begin
        crc_d = wsfc_crc_word(crc_q, nvm_q[idx_q]);
        fcrc_d = wsfc_crc_word(fcrc_q, FACT_IMG[idx_q]);
        idx_d = idx_q + 3'h1;
        if (idx_q == 3'(NVM_WORDS - 1)) begin
          st_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        fail_user_d = (crc_q != nvm_crc_q);
        fail_fact_d = (fcrc_q != FACT_CRC);
        if ((crc_q != nvm_crc_q) || (fcrc_q != FACT_CRC)) begin
          cfg_d = FACT_IMG;
        end else begin
          cfg_d = nvm_q;
        end
        st_d = ST_RUN;
      end
      ST_PROG: begin
        nvm_d[idx_q] = cfg_q[idx_q];
        crc_d = wsfc_crc_word(crc_q, cfg_q[idx_q]);
        idx_d = idx_q + 3'h1;
        if (idx_q == 3'(NVM_WORDS - 1)) begin
          nvm_crc_d = crc_d;
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr_fire && address == OFS_TRIGGER) begin
          if (tr_rst == RESET_CODE) begin
            st_d = ST_DELAY;
            cnt_d = '0;
            fail_user_d = 1'b0;
            fail_fact_d = 1'b0;
          end else begin
            if (tr_byp == BYPASS_CODE) begin
              cfg_d[W_COMMON][F_LOCK] = 1'b0;
            end
            if (writedata[F_PROG]) begin
              st_d = ST_PROG;
              idx_d = '0;
              crc_d = CRC_INIT;
            end
          end
        end else if (wr_fire && !address[5] && address[1:0] == 2'h0 && !locked) begin
          cfg_d[address[4:2]] = (cfg_q[address[4:2]] & ~(wmask & WR_MASK[address[4:2]]))
                              | (writedata[15:0] & wmask & WR_MASK[address[4:2]]);
        end
      end
    endcase
    // Registered decode keeps the boot flag a plain flop output
    boot_d = (st_d == ST_RUN);
  end

  // Control group registers; the store survives a software reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= ST_DELAY;
      cfg_q <= FACT_IMG;
      nvm_q <= FACT_IMG;
      nvm_crc_q <= FACT_CRC;
      crc_q <= CRC_INIT;
      fcrc_q <= CRC_INIT;
      cnt_q <= '0;
      idx_q <= '0;
      fail_user_q <= 1'b0;
      fail_fact_q <= 1'b0;
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= '0;
      boot_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      nvm_q <= nvm_d;
      nvm_crc_q <= nvm_crc_d;
      crc_q <= crc_d;
      fcrc_q <= fcrc_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      fail_user_q <= fail_user_d;
      fail_fact_q <= fail_fact_d;
      ack_q <= ack_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      boot_q <= boot_d;
    end
  end

  // Lock, reset and boot checks on the control group
  property p_lock;
    @(posedge clock) disable iff (!rstn)
      (ce && wr_fire && locked && address != OFS_TRIGGER) |=> $stable(cfg_q);
  endproperty
  a_lock: assert property (p_lock) else $error("write passed the lock");
  property p_soft_reset;
    @(posedge clock) disable iff (!rstn)
      (ce && wr_fire && address == OFS_TRIGGER && tr_rst == RESET_CODE)
      |=> st_q == ST_DELAY && !fail_user_q && !fail_fact_q && waitrequest;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset not taken");
  property p_bypass;
    @(posedge clock) disable iff (!rstn)
      (ce && wr_fire && address == OFS_TRIGGER && tr_rst != RESET_CODE
       && tr_byp == BYPASS_CODE) |=> !locked;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass code left lock set");
  property p_fail_hold;
    @(posedge clock) disable iff (!rstn)
      (st_q == ST_PROG || st_q == ST_CHECK) |=> $stable({fail_user_q, fail_fact_q});
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail bits moved outside boot");
  property p_boot_wait;
    @(posedge clock) disable iff (!rstn)
      (st_q != ST_RUN) |-> waitrequest;
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("bus answered during boot");
  property p_fact_load;
    @(posedge clock) disable iff (!rstn)
      (ce && st_q == ST_LOAD && (crc_q != nvm_crc_q)) |=> cfg_q == FACT_IMG && fail_user_q;
  endproperty
  a_fact_load: assert property (p_fact_load) else $error("factory image not loaded");

  // ----------------------------------------------------------------
  // Ramp sequencer
  // ----------------------------------------------------------------
  assign run = cfg_q[W_FUNC][F_SEQ_RUN] & (st_q == ST_RUN);
  assign shape = cfg_q[W_FUNC][F_SHAPE_LSB +: 3];
  assign lo = {1'b0, cfg_q[W_MIN][CODE_W-1:0]};
  assign hi = {1'b0, cfg_q[W_MAX][CODE_W-1:0]};
  assign stp = {7'h00, cfg_q[W_FUNC][F_CSTEP_LSB +: 4]} + 11'h001;
  assign up_v = {1'b0, code_q} + stp;
  assign dn_v = ({1'b0, code_q} > stp) ? {1'b0, code_q} - stp : 11'h000;
  assign step_tick = (osc_q == OSC_TICK_CYC - 16'h0001)
                   && (tcnt_q == cfg_q[W_FUNC][F_TSTEP_LSB +: 4]);

  // Step timing and code update
  always_comb begin
    osc_d = (osc_q == OSC_TICK_CYC - 16'h0001) ? 16'h0000 : osc_q + 16'h0001;
    tcnt_d = tcnt_q;
    if (osc_q == OSC_TICK_CYC - 16'h0001) begin
      tcnt_d = step_tick ? 4'h0 : tcnt_q + 4'h1;
    end
    code_d = code_q;
    dir_down_d = dir_down_q;
    if (!run) begin
      osc_d = '0;
      tcnt_d = '0;
      dir_down_d = 1'b0;
      if (st_q != ST_RUN) begin
        code_d = '0;
      end
    end else if (step_tick) begin
      unique case (shape)
        SHAPE_TRI: begin
          if (!dir_down_q) begin
            code_d = clamp(up_v, lo, hi);
            dir_down_d = (up_v >= hi);
          end else begin
            code_d = clamp(dn_v, lo, hi);
            dir_down_d = ~(dn_v <= lo);
          end
        end
        // wrap to starting level after the end
        SHAPE_SAW: code_d = ({1'b0, code_q} >= hi) ? lo[CODE_W-1:0] : clamp(up_v, lo, hi);
        SHAPE_ISAW: code_d = ({1'b0, code_q} <= lo) ? hi[CODE_W-1:0] : clamp(dn_v, lo, hi);
        default: code_d = lo[CODE_W-1:0];
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      osc_q <= '0;
      tcnt_q <= '0;
      code_q <= '0;
      dir_down_q <= 1'b0;
    end else if (ce) begin
      osc_q <= osc_d;
      tcnt_q <= tcnt_d;
      code_q <= code_d;
      dir_down_q <= dir_down_d;
    end
  end

  // Every step lands inside the programmed levels unless they cross
  property p_clamp;
    @(posedge clock) disable iff (!rstn)
      (ce && run && step_tick && shape <= SHAPE_ISAW && lo <= hi)
      |=> ({1'b0, code_q} >= $past(lo)) && ({1'b0, code_q} <= $past(hi));
  endproperty
  a_clamp: assert property (p_clamp) else $error("ramp code left the levels");

  // ----------------------------------------------------------------
  // Analog and comparator controls
  // ----------------------------------------------------------------
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      // external reference on its gain code
      ext_d[ch] = (cfg_q[ch][F_GAIN_LSB +: 3] == GAIN_EXT_REF);
      hiz_d[ch] = cfg_q[ch][F_FB_HIZ];
      if (cfg_q[ch][F_CMP_EN] && cfg_q[ch][F_CMP_OUT_EN]) begin
        if (cfg_q[ch][F_CMP_OD]) begin
          cmp_o_d[ch] = 1'b0;
          cmp_oe_d[ch] = ~(raw_s_q[ch] ^ cfg_q[ch][F_CMP_INV]);
        end else begin
          cmp_o_d[ch] = raw_s_q[ch] ^ cfg_q[ch][F_CMP_INV];
          cmp_oe_d[ch] = 1'b1;
        end
      end else begin
        cmp_o_d[ch] = 1'b0;
        cmp_oe_d[ch] = 1'b0;
      end
    end
    mode_dis_d = cfg_q[W_MODE][F_MODE_IN_DIS];
  end

  // Output registers, so every pin comes from a flop
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ext_q <= 2'h0;
      hiz_q <= 2'h0;
      cmp_o_q <= 2'h0;
      cmp_oe_q <= 2'h0;
      mode_dis_q <= 1'b0;
    end else if (ce) begin
      ext_q <= ext_d;
      hiz_q <= hiz_d;
      cmp_o_q <= cmp_o_d;
      cmp_oe_q <= cmp_oe_d;
      mode_dis_q <= mode_dis_d;
    end
  end

  // Comparator stage and reference select checks
  property p_cmp_gate;
    @(posedge clock) disable iff (!rstn)
      (ce && !(cfg_q[0][F_CMP_EN] && cfg_q[0][F_CMP_OUT_EN])) |=> !cmp_oe_q[0];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("comparator drove while disabled");
  property p_od_low;
    @(posedge clock) disable iff (!rstn)
      (ce && cfg_q[1][F_CMP_EN] && cfg_q[1][F_CMP_OUT_EN] && cfg_q[1][F_CMP_OD]) |=> !cmp_o_q[1];
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain output drove high");
  property p_invert;
    @(posedge clock) disable iff (!rstn)
      (ce && cfg_q[0][F_CMP_EN] && cfg_q[0][F_CMP_OUT_EN] && !cfg_q[0][F_CMP_OD])
      |=> cmp_o_q[0] == ($past(raw_s_q[0]) ^ $past(cfg_q[0][F_CMP_INV]));
  endproperty
  a_invert: assert property (p_invert) else $error("comparator polarity wrong");
  property p_ext_ref;
    @(posedge clock) disable iff (!rstn)
      ce |=> ext_ref_sel[0] == ($past(cfg_q[0][2:0]) == GAIN_EXT_REF);
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("reference select mismatch");

  // ten-bit code straight from its flop
  assign dac_code = code_q;
  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign ext_ref_sel = ext_q;
  assign feedback_high_impedance_select = hiz_q;
  assign cmp_o = cmp_o_q;
  assign cmp_oe = cmp_oe_q;
  assign mode_pin_input_disable = mode_dis_q;
  assign boot_done = boot_q;

endmodule

// *** test/wsfc_host_model.sv ***
/*
  Host model: Avalon-MM master standing in for the serial programming host.
  Assumes a slave that answers every request with one waitrequest-low cycle.
*/
`timescale 1ns/1ns
module wsfc_host_model
  import wsfc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Avalon-MM master side
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  // --------------------------------------------------------------
  // Bus cycle
  // --------------------------------------------------------------
  // Idle bus at time zero; every lane enabled
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hF;
  end

  // one held request per answer
  // Released lines show the inverse so stale values cannot pass as fresh
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    ok = 1'b0;
    // Sample the answer at the rising edge that also commits it
    for (int i = 0; i < 3000 && !ok; i++) begin
      @(posedge clock);
      ok = (waitrequest === 1'b0);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule

// *** test/test_wave_sequencer_fault_ctrl.sv ***
/*
  Self-checking bench for the wave sequencer core: register access, lock,
  software reset, comparator stage and ramp shapes.
  Assumes the host model drives the register bus; ce is held high.
*/
`timescale 1ns/1ns
module test_wave_sequencer_fault_ctrl
  import wsfc_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, ce = 1'b1, wr_s, rd_s, boot_done;
  logic [1:0] cmp_raw = 2'b00, ext_ref_sel, fb_hiz, cmp_o, cmp_oe;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic waitrequest, mode_dis;
  logic [CODE_W-1:0] dac_code;
  int failures = 0, cmp_count = 0;

  always #5 clock = ~clock;

  wsfc_core i_wsfc_core (.clock(clock), .rstn(rstn), .ce(ce), .address(address),
    .read(rd_s), .write(wr_s), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .cmp_raw(cmp_raw), .dac_code(dac_code),
    .ext_ref_sel(ext_ref_sel), .mode_pin_input_disable(mode_dis),
    .feedback_high_impedance_select(fb_hiz), .cmp_o(cmp_o), .cmp_oe(cmp_oe),
    .boot_done(boot_done));
  wsfc_host_model i_wsfc_host_model (.clock(clock), .address(address), .read(rd_s),
    .write(wr_s), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  // --------------------------------------------------------------
  // Report and bus helpers
  // --------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // A bus wait that runs out ends the run at once
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    bit ok;
    i_wsfc_host_model.xfer(w, a, d, q, ok);
    if (!ok) begin
      failures++;
      conclude();
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic r(input string n, input logic [5:0] a, input logic [31:0] e,
                   input logic [31:0] m);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
  endtask
  // Code must stay in [lo,hi], touch both ends and move every 100 cycles
  task automatic ramp(input logic [2:0] sh, input logic [9:0] lo, input logic [9:0] hi);
    int gmin, gmax, gap, bad;
    bit hl, hh;
    logic [9:0] prev;
    gmin = 9999; gmax = 0; gap = -1; bad = 0; hl = 0; hh = 0;
    w(OFS_FUNC_MIN, {22'h0, lo});
    w(OFS_FUNC_MAX, {22'h0, hi});
    w(OFS_FUNC_CFG, 32'h808 | {29'h0, sh});
    repeat (250) @(posedge clock);
    prev = dac_code;
    repeat (1500) begin
      @(negedge clock);
      if (dac_code < lo || dac_code > hi) bad++;
      if (dac_code === lo) hl = 1;
      if (dac_code === hi) hh = 1;
      if (dac_code !== prev && gap >= 0) begin
        gmin = (gap + 1 < gmin) ? gap + 1 : gmin;
        gmax = (gap + 1 > gmax) ? gap + 1 : gmax;
      end
      gap = (dac_code !== prev) ? 0 : ((gap >= 0) ? gap + 1 : -1);
      prev = dac_code;
    end
    chk("ramp range", 0, bad);
    chk("ramp ends", 2'b11, {hl, hh});
    chk("step gap", {16'd100, 16'd100}, {gmin[15:0], gmax[15:0]});
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  logic [7:0] cfg [5] = '{8'h18, 8'h58, 8'h38, 8'h78, 8'h98};
  logic [2:0] exp_c [5] = '{3'b011, 3'b001, 3'b000, 3'b001, 3'b111};
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    r("max default", OFS_FUNC_MAX, 32'h3FF, 32'h3FF);
    chk("boot done", 1, boot_done);
    r("crc fails", OFS_STATUS, 0, 32'h3);
    $display("test boot done");
    w(OFS_DEV_MODE, 1);
    repeat (2) @(posedge clock);
    chk("mode disable", 1, mode_dis);
    w(OFS_FREQ_ERR, 32'hFE);
    r("freq err", OFS_FREQ_ERR, 32'hFFFE, 32'hFFFF);
    cmp_raw <= 2'b01;
    for (int i = 0; i < 5; i++) begin
      w(OFS_CMP_CFG0, {24'h0, cfg[i]});
      repeat (5) @(posedge clock);
      chk("fb o oe", exp_c[i], {fb_hiz[0], cmp_o[0], cmp_oe[0]});
      chk("ext ref", 1, ext_ref_sel[0]);
    end
    w(OFS_CMP_CFG0, 8'h08);
    repeat (5) @(posedge clock);
    chk("no out en", 0, cmp_oe[0]);
    $display("test comparator done");
    ramp(SHAPE_TRI, 10'h4, 10'h8);
    ramp(SHAPE_SAW, 10'h4, 10'h8);
    ramp(SHAPE_ISAW, 10'h3F8, 10'h3FF);
    w(OFS_FUNC_CFG, 0);
    w(OFS_CMP_CFG1, 8'h18);
    cmp_raw <= 2'b10;
    repeat (5) @(posedge clock);
    chk("ch1 compare", 2'b11, {cmp_o[1], cmp_oe[1]});
    $display("test ramp done");
    w(OFS_COMMON_CFG, 1);
    w(OFS_FUNC_MIN, 32'h55);
    r("locked", OFS_FUNC_MIN, 32'h3F8, 32'h3FF);
    w(OFS_TRIGGER, 32'h30);
    w(OFS_FUNC_MIN, 32'h55);
    r("bad code", OFS_FUNC_MIN, 32'h3F8, 32'h3FF);
    w(OFS_TRIGGER, 32'h50);
    w(OFS_FUNC_MIN, 32'h55);
    r("bypass", OFS_FUNC_MIN, 32'h55, 32'h3FF);
    w(OFS_TRIGGER, 32'h100);
    w(OFS_COMMON_CFG, 1);
    w(OFS_TRIGGER, 32'hA);
    r("reloaded", OFS_FUNC_MIN, 32'h55, 32'h3FF);
    r("unlocked", OFS_COMMON_CFG, 0, 32'h1);
    r("fails clear", OFS_STATUS, 0, 32'h3);
    r("unmapped", 6'h3C, 0, 32'hFFFFFFFF);
    $display("test lock and reset done");
    conclude();
  end
endmodule
